// ### hdl/adchc_pkg.sv
// package: constants for the converter control logic
package adchc_pkg;

	// =========================================
	// data layout
	localparam int unsigned DATA_W = 12;
	localparam int unsigned MSB_BYTE_W = 8;
	localparam int unsigned LSB_NIB_W = 4;
	localparam int unsigned SHORT_BITS = 8;
	localparam int unsigned BIT_THREE_POS = 3;
	localparam logic [11:0] SHORT_FILL = 12'h008;
	localparam logic [11:0] SHORT_MASK = 12'hff0;

	// =========================================
	// output enable patterns per read mode
	localparam logic [11:0] OE_NONE = 12'h000;
	localparam logic [11:0] OE_WORD = 12'hfff;
	localparam logic [11:0] OE_HIGH_BYTE = 12'hff0;
	localparam logic [11:0] OE_LOW_BYTE = 12'h0ff;

	// =========================================
	// conversion timing (ns) and derived cycle counts at 125 MHz
	localparam int unsigned CLK_PERIOD_NS = 8;
	localparam int unsigned CONV12_NS = 8000;
	localparam int unsigned CONV8_NS = 5600;
	localparam int unsigned CONV12_CYC = CONV12_NS / CLK_PERIOD_NS;
	localparam int unsigned CONV8_CYC = CONV8_NS / CLK_PERIOD_NS;
	localparam int unsigned CNT_W = 12;

	// =========================================
	// conversion state
	typedef enum logic [0:0] {
		ADCHC_IDLE,
		ADCHC_BUSY
	} adchc_state_e;

endpackage : adchc_pkg

// ### hdl/adchc_top.sv
// converter control: start detection, busy status and output enables
// =========================================
// Notes on behaviour
// - start when enable high, select low, read/convert low; last one to arrive starts it
// - any number of qualifying inputs changing together still give exactly one start
// - byte select captured at start; low runs 12 bits, high stops after 8
// - only byte select is latched; all other controls act on live levels
// - 12-bit read after 8-bit conversion gives zero low three bits, one on bit three
// - busy status high exactly while a conversion runs, low otherwise
// - data outputs stay high impedance while busy status is high
// - starts during busy are ignored; no restart, no reset of conversion
// - outputs enabled only with read high, busy low, enable high, select low
// - word-width high drives all twelve outputs and ignores byte select
// - word-width low, byte select low drives the eight upper result bits
// - word-width low, byte select high drives low four bits, bits 4-7 forced low
module adchc_top
	import adchc_pkg::*;
#(
	parameter int unsigned CONV12_CYCLES = CONV12_CYC,
	parameter int unsigned CONV8_CYCLES = CONV8_CYC
)
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// control inputs
	input wire logic unit_enable_i,
	input wire logic chip_select_b_i,
	input wire logic read_convert_i,
	input wire logic word_width_i,
	input wire logic byte_select_i,
	// result from the analog core, sampled at end of conversion
	input wire logic [adchc_pkg::DATA_W-1:0] conv_result_i,
	// status and data pins
	output logic busy_status_o,
	output logic [adchc_pkg::DATA_W-1:0] data_o,
	output logic [adchc_pkg::DATA_W-1:0] data_oe_o
);
	import adchc_pkg::*;

	// =========================================
	// start detection
	adchc_state_e state_ff;
	adchc_state_e nxt_state;
	logic start_cond_ff;
	logic short_ff;
	logic [CNT_W-1:0] cnt_ff;
	logic [CNT_W-1:0] nxt_cnt;
	logic [DATA_W-1:0] result_ff;
	logic [DATA_W-1:0] nxt_result;
	logic [DATA_W-1:0] nxt_data;
	logic [DATA_W-1:0] nxt_oe;
	logic nxt_short;

	// three live qualifiers; whichever settles last makes the edge
	wire en_ok = unit_enable_i;
	wire sel_ok = ~chip_select_b_i;
	wire conv_lvl = ~read_convert_i;
	wire start_cond = en_ok & sel_ok & conv_lvl;
	// one rising edge of the combined condition, however many inputs moved
	wire start_evt = start_cond & ~start_cond_ff;
	wire busy = (state_ff == ADCHC_BUSY);
	wire accept = start_evt & ~busy;
	wire conv_done = busy & (cnt_ff == '0);
	wire [CNT_W-1:0] load12 = CNT_W'(CONV12_CYCLES - 1);
	wire [CNT_W-1:0] load8 = CNT_W'(CONV8_CYCLES - 1);

	// =========================================
	// conversion sequencing
	always_comb
	begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		nxt_short = short_ff;
		nxt_result = result_ff;
		unique case (state_ff)
			ADCHC_IDLE:
			begin
				if (accept)
				begin
					nxt_state = ADCHC_BUSY;
					nxt_short = byte_select_i;
					nxt_cnt = byte_select_i ? load8 : load12;
				end
			end
			ADCHC_BUSY:
			begin
				if (conv_done)
				begin
					nxt_state = ADCHC_IDLE;
					// short conversion: low nibble reads as 1000
					nxt_result = short_ff ? ((conv_result_i & SHORT_MASK) | SHORT_FILL)
						: conv_result_i;
				end
				else
				begin
					nxt_cnt = cnt_ff - CNT_W'(1);
				end
			end
		endcase
	end

	// =========================================
	// read mode decode from live control levels
	// busy as it will stand after this edge
	wire nxt_busy = (nxt_state == ADCHC_BUSY);
	// enables follow next-state busy so the pins never lag the status pin
	wire read_ok = read_convert_i & ~nxt_busy & unit_enable_i & ~chip_select_b_i;
	// byte select acts live here; only its copy for the length is latched
	wire sel_word = read_ok & word_width_i;
	wire sel_high = read_ok & ~word_width_i & ~byte_select_i;
	wire sel_low = read_ok & ~word_width_i & byte_select_i;

	// read modes; off covers every case in which the pins stay released
	typedef enum logic [1:0] {
		ADCHC_RD_OFF,
		ADCHC_RD_WORD,
		ADCHC_RD_HIGH,
		ADCHC_RD_LOW
	} adchc_rd_mode_e;

	adchc_rd_mode_e rd_mode;

	// word width wins, so byte select is a don't-care in word mode
	always_comb
	begin
		rd_mode = ADCHC_RD_OFF;
		if (sel_word)
		begin
			rd_mode = ADCHC_RD_WORD;
		end
		else if (sel_high)
		begin
			rd_mode = ADCHC_RD_HIGH;
		end
		else if (sel_low)
		begin
			rd_mode = ADCHC_RD_LOW;
		end
	end

	// =========================================
	// data patterns per read mode
	// lines not enabled carry zero, so a released pin never shows stale data
	wire [DATA_W-1:0] word_data = nxt_result & OE_WORD;
	wire [DATA_W-1:0] high_data = nxt_result & OE_HIGH_BYTE;
	// upper nibble released, bits 7:4 driven low, low nibble from the result
	wire [DATA_W-1:0] low_data = {8'h00, nxt_result[3:0]};

	always_comb
	begin
		nxt_oe = OE_NONE;
		nxt_data = '0;
		unique case (rd_mode)
			ADCHC_RD_OFF:
			begin
				nxt_oe = OE_NONE;
				nxt_data = '0;
			end
			ADCHC_RD_WORD:
			begin
				nxt_oe = OE_WORD;
				nxt_data = word_data;
			end
			ADCHC_RD_HIGH:
			begin
				nxt_oe = OE_HIGH_BYTE;
				nxt_data = high_data;
			end
			ADCHC_RD_LOW:
			begin
				nxt_oe = OE_LOW_BYTE;
				nxt_data = low_data;
			end
		endcase
	end

	// =========================================
	// sequencer state
	// only the sequencer decides whether a start edge is taken
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			state_ff <= ADCHC_IDLE;
		end
		else
		begin
			state_ff <= nxt_state;
		end
	end

	// =========================================
	// start level history
	// resets low, so a start level present at release begins a conversion
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			start_cond_ff <= 1'b0;
		end
		else
		begin
			start_cond_ff <= start_cond;
		end
	end

	// =========================================
	// latched length select
	// the one stored control; reads still use the live byte select
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			short_ff <= 1'b0;
		end
		else
		begin
			short_ff <= nxt_short;
		end
	end

	// =========================================
	// conversion counter
	// loads once per start and is never reloaded while busy
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			cnt_ff <= '0;
		end
		else
		begin
			cnt_ff <= nxt_cnt;
		end
	end

	// =========================================
	// stored result
	// holds the last result until the next conversion ends
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			result_ff <= '0;
		end
		else
		begin
			result_ff <= nxt_result;
		end
	end

	// =========================================
	// busy status pin
	// taken from next state, so it rises at the very edge that takes the start
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			busy_status_o <= 1'b0;
		end
		else
		begin
			busy_status_o <= nxt_busy;
		end
	end

	// =========================================
	// data pins
	// zero on every line that is not enabled
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			data_o <= '0;
		end
		else
		begin
			data_o <= nxt_data;
		end
	end

	// =========================================
	// data pin enables
	// released for the whole conversion, one cycle behind the live controls
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			data_oe_o <= OE_NONE;
		end
		else
		begin
			data_oe_o <= nxt_oe;
		end
	end

endmodule : adchc_top

// ### verif/adchc_core_model.sv
// partner: analog core stand-in feeding the conversion result
module adchc_core_model #(parameter logic [11:0] RES = 12'ha5c) (
	// status in, result out
	input wire logic busy_i,
	output logic [11:0] res_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// inverse outside a conversion, so a capture at the wrong moment shows
	assign res_o = busy_i ? RES : ~RES;
endmodule : adchc_core_model

// ### verif/adchc_top_monitor.sv
// checker: pin assertions for the converter control
module adchc_top_monitor
	import adchc_pkg::*;
(
	// watched pins
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic unit_enable_i,
	input wire logic chip_select_b_i,
	input wire logic read_convert_i,
	input wire logic word_width_i,
	input wire logic byte_select_i,
	input wire logic busy_status_o,
	input wire logic [adchc_pkg::DATA_W-1:0] data_o,
	input wire logic [adchc_pkg::DATA_W-1:0] data_oe_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========
	// live levels: reset folded into rd so the first edge after release stays quiet
	wire st = unit_enable_i & ~chip_select_b_i & ~read_convert_i;
	wire rd = rst_b_i & unit_enable_i & ~chip_select_b_i & read_convert_i;
	wire bw = rd & ~word_width_i;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_b_i);
	a_start_busy: assert property ($rose(st) && !busy_status_o |=> busy_status_o)
		else $error("no start");
	a_busy_cause: assert property ($rose(busy_status_o) |-> $past(st)) else $error("stray");
	a_oe_busy: assert property (busy_status_o |-> data_oe_o == OE_NONE) else $error("oe");
	a_oe_gate: assert property (data_oe_o != OE_NONE |-> $past(rd)) else $error("gate");
	a_word_all: assert property ($past(rd && word_width_i) && !busy_status_o
		|-> data_oe_o == OE_WORD) else $error("word");
	a_high_byte: assert property ($past(bw && !byte_select_i) && !busy_status_o
		|-> data_oe_o == OE_HIGH_BYTE && data_o[3:0] == 4'h0) else $error("high");
	a_low_byte: assert property ($past(bw && byte_select_i) && !busy_status_o
		|-> data_oe_o == OE_LOW_BYTE && data_o[7:4] == 4'h0) else $error("low");
	a_off_zero: assert property (data_oe_o == OE_NONE |-> data_o == 12'h000) else $error("off");
endmodule : adchc_top_monitor
bind adchc_top adchc_top_monitor mon_u (.*);

// ### verif/adchc_top_test.sv
// testbench: self-checking run of the converter control
module adchc_top_test;
	timeunit 1ns;
	timeprecision 1ps;
	import adchc_pkg::*;
	// ==========
	// pins, counters, instances
	logic clk_i = 0, rst_b_i = 0, unit_enable_i = 0, chip_select_b_i = 1, read_convert_i = 1;
	logic word_width_i = 1, byte_select_i = 0, busy_status_o;
	logic [11:0] conv_result_i, data_o, data_oe_o;
	int mismatches = 0, samples_checked = 0;
	adchc_core_model core_u (.busy_i(busy_status_o), .res_o(conv_result_i));
	adchc_top #(.CONV12_CYCLES(12), .CONV8_CYCLES(8)) dut_u (.*);
	initial forever #4 clk_i = ~clk_i;
	task chk(string n, logic [11:0] e, g);
		samples_checked++;
		mismatches += int'(g !== e);
		if (g !== e) $display("mismatch %s exp %h got %h", n, e, g);
	endtask : chk
	// counts busy over a fixed window; a start pulse lands mid-conversion
	task conv(logic [11:0] n);
		int c;
		c = 0;
		for (int k = 0; k < 40; k++)
		begin
			@(posedge clk_i);
			read_convert_i <= k == 3;
			@(negedge clk_i);
			c += int'(busy_status_o === 1'b1);
			if (busy_status_o) chk("oe", OE_NONE, data_oe_o);
		end
		chk("busy", n, 12'(c));
	endtask : conv
	task rd(logic w, b, logic [11:0] oe, d);
		@(posedge clk_i);
		{word_width_i, byte_select_i, read_convert_i} <= {w, b, 1'h1};
		@(posedge clk_i);
		@(negedge clk_i);
		chk("oe", oe, data_oe_o);
		chk("data", d, data_o);
	endtask : rd
	task t_long;
		@(posedge clk_i);
		{unit_enable_i, chip_select_b_i, read_convert_i} <= 3'h4;
		conv(12'h00c);
		rd(1, 1, OE_WORD, 12'ha5c);
		$display("t_long done");
	endtask : t_long
	task t_short;
		@(posedge clk_i);
		{chip_select_b_i, read_convert_i, byte_select_i} <= 3'h5;
		@(posedge clk_i);
		chip_select_b_i <= 0;
		conv(12'h008);
		rd(1, 0, OE_WORD, 12'ha58);
		rd(0, 0, OE_HIGH_BYTE, 12'ha50);
		rd(0, 1, OE_LOW_BYTE, 12'h008);
		@(posedge clk_i);
		unit_enable_i <= 0;
		rd(1, 0, OE_NONE, 12'h000);
		$display("t_short done");
	endtask : t_short
	task wrap_up;
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : wrap_up
	initial
	begin
		repeat (16) @(posedge clk_i);
		rst_b_i <= 1;
		t_long();
		t_short();
		wrap_up();
	end
endmodule : adchc_top_test
